// *** src/afw_defines.svh ***
// constants for the measurement window selector block
`ifndef AFW_DEFINES_SVH
`define AFW_DEFINES_SVH
// ******************************************************************
// register byte offsets
// ******************************************************************
`define AFW_OFS_SELECT      5'h00
`define AFW_OFS_XOFF        5'h04
`define AFW_OFS_WIDTH       5'h08
`define AFW_OFS_YOFF        5'h0c
`define AFW_OFS_HEIGHT      5'h10
`define AFW_OFS_ASSIGN      5'h14
`define AFW_OFS_CONTROL     5'h18
`define AFW_OFS_STATUS      5'h1c
// ******************************************************************
// field positions
// ******************************************************************
`define AFW_ASG_BRIGHT_BIT  0
`define AFW_ASG_COLOR_BIT   1
`define AFW_CTL_GAIN_LSB    0
`define AFW_CTL_EXPO_LSB    2
`define AFW_CTL_BAL_LSB     4
`define AFW_CTL_COLOR_BIT   6
`define AFW_CTL_BIN_BIT     7
// ******************************************************************
// reset values and timing counts
// ******************************************************************
`define AFW_RST_SELECT      1'b0
`define AFW_RST_XOFF        12'h000
`define AFW_RST_YOFF        12'h000
`define AFW_RST_ASG_WIN0    2'h1
`define AFW_RST_ASG_WIN1    2'h2
`define AFW_ONCE_MAX_FRAMES 5'h1e
`define AFW_START_DELAY     2'h2
`endif

// *** src/afw_pkg.sv ***
// types shared by the measurement window selector block
package afw_pkg;
  typedef enum logic [1:0] {AFW_OFF, AFW_ONCE, AFW_CONT} afw_mode_t;

  typedef struct packed {
    logic        sof;
    logic        eol;
    logic        eof;
    logic        valid;
    logic [11:0] col;
    logic [11:0] row;
    logic [11:0] data;
  } afw_pix_t;

  typedef struct packed {
    logic [11:0] xoff;
    logic [11:0] width;
    logic [11:0] yoff;
    logic [11:0] height;
  } afw_win_t;

  typedef struct packed {
    logic        valid;
    logic        overlap;
    logic [31:0] sum;
    logic [23:0] count;
  } afw_stat_t;
endpackage

// *** src/afw_win_stats.sv ***
// per-window overlap test and pixel accumulator
`timescale 1ns/1ps
`include "afw_defines.svh"
module afw_win_stats
(
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire afw_pkg::afw_win_t i_win,
  input  wire afw_pkg::afw_win_t i_img,
  input  wire afw_pkg::afw_pix_t i_pix,
  output afw_pkg::afw_stat_t     o_stat
);
  typedef struct packed {
    logic [31:0]        sum;
    logic [23:0]        count;
    afw_pkg::afw_stat_t stat;
  } afw_ws_state_t;

  afw_ws_state_t st_reg;
  afw_ws_state_t st_next;
  logic          in_win;
  logic          in_img;
  logic          take;
  logic [12:0]   wx_end;
  logic [12:0]   wy_end;
  logic [12:0]   ix_end;
  logic [12:0]   iy_end;
  logic          ovl;

  // coordinates count from column 0, row 0 at the upper-left corner
  always_comb
  begin
    wx_end = {1'b0, i_win.xoff} + {1'b0, i_win.width};
    wy_end = {1'b0, i_win.yoff} + {1'b0, i_win.height};
    ix_end = {1'b0, i_img.xoff} + {1'b0, i_img.width};
    iy_end = {1'b0, i_img.yoff} + {1'b0, i_img.height};
    in_win = ({1'b0, i_pix.col} >= {1'b0, i_win.xoff}) && ({1'b0, i_pix.col} < wx_end) &&
             ({1'b0, i_pix.row} >= {1'b0, i_win.yoff}) && ({1'b0, i_pix.row} < wy_end);
    in_img = ({1'b0, i_pix.col} >= {1'b0, i_img.xoff}) && ({1'b0, i_pix.col} < ix_end) &&
             ({1'b0, i_pix.row} >= {1'b0, i_img.yoff}) && ({1'b0, i_pix.row} < iy_end);
    take   = i_pix.valid && in_win && in_img;
    ovl    = ({1'b0, i_win.xoff} < ix_end) && ({1'b0, i_img.xoff} < wx_end) &&
             ({1'b0, i_win.yoff} < iy_end) && ({1'b0, i_img.yoff} < wy_end) &&
             (i_win.width != 12'h000) && (i_win.height != 12'h000);
  end

  always_comb
  begin
    st_next = st_reg;
    st_next.stat.valid = 1'b0;
    if (i_pix.sof)
    begin
      st_next.sum   = 32'h0000_0000;
      st_next.count = 24'h00_0000;
    end
    if (take)
    begin
      st_next.sum   = (i_pix.sof ? 32'h0000_0000 : st_reg.sum) + {20'h0_0000, i_pix.data};
      st_next.count = (i_pix.sof ? 24'h00_0000 : st_reg.count) + 24'h00_0001;
    end
    if (i_pix.eof)
    begin
      st_next.stat.valid   = 1'b1;
      st_next.stat.overlap = ovl && (st_next.count != 24'h00_0000);
      st_next.stat.sum     = st_next.sum;
      st_next.stat.count   = st_next.count;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign o_stat = st_reg.stat;

  a_stat_pulse_once: assert property (@(posedge i_clk) disable iff (i_rst)
    o_stat.valid |=> !o_stat.valid)
    else $error("frame statistics valid longer than one cycle");
  a_eof_gives_stat: assert property (@(posedge i_clk) disable iff (i_rst)
    i_pix.eof |=> o_stat.valid)
    else $error("frame end gave no statistics");
  a_no_ovl_no_count: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_stat.valid && o_stat.count == 24'h00_0000) |-> !o_stat.overlap)
    else $error("empty overlap flagged as overlap");
endmodule

// *** src/afw_func_ctrl.sv ***
// mode sequencing for one automatic function
`timescale 1ns/1ps
`include "afw_defines.svh"
module afw_func_ctrl
(
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  input  wire afw_pkg::afw_mode_t i_mode,
  input  wire logic               i_mode_wr,
  input  wire logic               i_frame_done,
  input  wire logic               i_overlap,
  input  wire logic               i_reached,
  output logic                    o_active,
  output logic                    o_adjust,
  output logic                    o_once_done
);
  typedef struct packed {
    afw_pkg::afw_mode_t mode;
    logic [1:0]         delay;
    logic [4:0]         frames;
    logic               adjust;
    logic               done;
  } afw_fc_state_t;

  afw_fc_state_t st_reg;
  afw_fc_state_t st_next;

  always_comb
  begin
    st_next = st_reg;
    st_next.adjust = 1'b0;
    st_next.done   = 1'b0;
    if (i_mode_wr)
    begin
      st_next.mode   = i_mode;
      st_next.delay  = `AFW_START_DELAY;
      st_next.frames = 5'h00;
    end
    else if (i_frame_done && st_reg.mode != afw_pkg::AFW_OFF)
    begin
      if (st_reg.delay != 2'h0)
        st_next.delay = st_reg.delay - 2'h1;
      else
      begin
        st_next.adjust = i_overlap;
        st_next.frames = st_reg.frames + 5'h01;
        if (st_reg.mode == afw_pkg::AFW_ONCE &&
            (i_reached || st_next.frames == `AFW_ONCE_MAX_FRAMES))
        begin
          st_next.mode = afw_pkg::AFW_OFF;
          st_next.done = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign o_active    = (st_reg.mode != afw_pkg::AFW_OFF);
  assign o_adjust    = st_reg.adjust;
  assign o_once_done = st_reg.done;

  a_once_bounded: assert property (@(posedge i_clk) disable iff (i_rst)
    st_reg.frames <= `AFW_ONCE_MAX_FRAMES || st_reg.mode != afw_pkg::AFW_ONCE)
    else $error("once mode ran past its frame limit");
  a_no_adj_no_ovl: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_frame_done && !i_overlap && !i_mode_wr) |=> !o_adjust)
    else $error("adjustment without overlap");
  a_start_delay: assert property (@(posedge i_clk) disable iff (i_rst)
    i_mode_wr |=> !o_adjust)
    else $error("adjustment right after enabling");
endmodule

// *** src/afw_top.sv ***
// measurement window selection for the automatic brightness and colour loops
// ******************************************************************
// Overview of operation
// - window coordinates count from column 0, row 0 at upper-left corner
// - each window has x offset, width, y offset and height
// - window settings are separate from output image window settings
// - functions use only pixels in window and output image overlap
// - overlap statistics drive adjustment of the whole image
// - no overlap means the function makes no adjustment
// - reset: brightness on window 1, colour balance on window 2
// - any function may be assigned to any window, even one shared
// - gain and exposure share one brightness assignment flag per window
// - gain and exposure are enabled independently
// - after reset every window covers the full sensor
// - x offset plus width must not exceed sensor width
// - y offset plus height must not exceed sensor height
// - size steps of 2 on monochrome, 4 on colour sensors
// - colour window steps match the output image window steps
// - with binning, coordinates are binned columns and lines
// - enabling a function takes effect after a short delay
// - once mode gives up after 30 frames and turns off
// - no overlap for gain means the manual gain value stays
// ******************************************************************
`timescale 1ns/1ps
`include "afw_defines.svh"
module afw_top
#(
  parameter int unsigned SENSOR_W = 1040,
  parameter int unsigned SENSOR_H = 1040,
  parameter int unsigned NUM_WIN  = 2
)
(
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic [4:0]        i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [31:0]       i_avs_writedata,
  input  wire logic [3:0]        i_avs_byteenable,
  output logic [31:0]            o_avs_readdata,
  output logic                   o_avs_waitrequest,
  input  wire afw_pkg::afw_pix_t i_pix,
  input  wire afw_pkg::afw_win_t i_img,
  input  wire logic [11:0]       i_manual_gain,
  input  wire logic [11:0]       i_target,
  output afw_pkg::afw_stat_t     o_bright_stat,
  output afw_pkg::afw_stat_t     o_color_stat,
  output logic                   o_gain_adjust,
  output logic                   o_expo_adjust,
  output logic                   o_bal_adjust,
  output logic [11:0]            o_gain_value
);
  // ******************************************************************
  // parameter checks
  // ******************************************************************
  initial
  begin
    if (NUM_WIN != 2 || SENSOR_W > 4095 || SENSOR_H > 4095 || SENSOR_W < 4 || SENSOR_H < 4)
      $error("afw_top: unsupported parameters");
  end

  localparam logic [11:0] FULL_W = SENSOR_W[11:0];
  localparam logic [11:0] FULL_H = SENSOR_H[11:0];

  typedef struct packed {
    logic                      sel;
    afw_pkg::afw_win_t [1:0]   win;
    logic [1:0][1:0]           asg;
    logic                      color;
    logic                      bin;
    logic                      ack;
    logic [31:0]               rdata;
  } afw_top_state_t;

  afw_top_state_t     st_reg;
  afw_top_state_t     st_next;
  afw_pkg::afw_stat_t wstat [2];
  afw_pkg::afw_stat_t bright_next;
  afw_pkg::afw_stat_t color_next;
  afw_pkg::afw_stat_t bright_reg;
  afw_pkg::afw_stat_t color_reg;
  logic               req;
  logic               wr_ctl;
  logic [11:0]        step_mask;
  logic               reached;
  logic [2:0]         fn_active;
  logic [2:0]         fn_adjust;
  logic [11:0]        gain_reg;
  logic [11:0]        mean_hi;

  // ******************************************************************
  // per-window statistics
  // ******************************************************************
  generate
    for (genvar w = 0; w < 2; w++)
    begin : g_win
      afw_win_stats u_stats
      (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_win  (st_reg.win[w]),
        .i_img  (i_img),
        .i_pix  (i_pix),
        .o_stat (wstat[w])
      );
    end
  endgenerate

  // merge windows carrying each assignment; software should keep one per function
  always_comb
  begin
    bright_next = '0;
    color_next  = '0;
    for (int w = 0; w < 2; w++)
    begin
      if (st_reg.asg[w][`AFW_ASG_BRIGHT_BIT] && wstat[w].valid)
      begin
        bright_next.valid   = 1'b1;
        bright_next.overlap = bright_next.overlap | wstat[w].overlap;
        bright_next.sum     = bright_next.sum + wstat[w].sum;
        bright_next.count   = bright_next.count + wstat[w].count;
      end
      if (st_reg.asg[w][`AFW_ASG_COLOR_BIT] && wstat[w].valid)
      begin
        color_next.valid   = 1'b1;
        color_next.overlap = color_next.overlap | wstat[w].overlap;
        color_next.sum     = color_next.sum + wstat[w].sum;
        color_next.count   = color_next.count + wstat[w].count;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      bright_reg <= '0;
      color_reg  <= '0;
    end
    else
    begin
      bright_reg <= bright_next;
      color_reg  <= color_next;
    end
  end

  // crude mean test: sum divided by count, truncated to 12 bits, compared against target
  assign mean_hi = (bright_reg.count == 24'h00_0000) ? 12'h000 :
                   12'(bright_reg.sum / {8'h00, bright_reg.count});
  assign reached = (mean_hi == i_target);

  // ******************************************************************
  // per-function mode control
  // ******************************************************************
  // writes land only on the edge that ends the wait, never on the stalled one
  assign wr_ctl = i_avs_write && (i_avs_address == `AFW_OFS_CONTROL) && st_reg.ack;

  generate
    for (genvar f = 0; f < 3; f++)
    begin : g_fn
      localparam int LSB = 2 * f;
      afw_func_ctrl u_fn
      (
        .i_clk        (i_clk),
        .i_rst        (i_rst),
        .i_mode       (afw_pkg::afw_mode_t'(i_avs_writedata[LSB +: 2])),
        .i_mode_wr    (wr_ctl && i_avs_byteenable[0]),
        .i_frame_done ((f == 2) ? color_reg.valid : bright_reg.valid),
        .i_overlap    ((f == 2) ? color_reg.overlap : bright_reg.overlap),
        .i_reached    (reached),
        .o_active     (fn_active[f]),
        .o_adjust     (fn_adjust[f]),
        .o_once_done  ()
      );
    end
  endgenerate

  assign o_gain_adjust = fn_adjust[0];
  assign o_expo_adjust = fn_adjust[1];
  assign o_bal_adjust  = fn_adjust[2];
  assign o_bright_stat = bright_reg;
  assign o_color_stat  = color_reg;

  // gain falls back to the manual value whenever no overlap feeds it
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      gain_reg <= 12'h000;
    else if (!fn_active[0] || (bright_reg.valid && !bright_reg.overlap))
      gain_reg <= i_manual_gain;
    else if (fn_adjust[0])
      gain_reg <= (mean_hi < i_target) ? gain_reg + 12'h001 :
                  (mean_hi > i_target) ? gain_reg - 12'h001 : gain_reg;
  end
  assign o_gain_value = gain_reg;

  // ******************************************************************
  // register file
  // ******************************************************************
  assign req       = (i_avs_read || i_avs_write) && !st_reg.ack;
  assign step_mask = st_reg.color ? 12'hffc : 12'hffe;

  always_comb
  begin
    st_next     = st_reg;
    st_next.ack = req;
    if (i_avs_write && st_reg.ack && i_avs_byteenable[0])
    begin
      case (i_avs_address)
        `AFW_OFS_SELECT:
          st_next.sel = i_avs_writedata[0];
        `AFW_OFS_XOFF:
          if ({1'b0, i_avs_writedata[11:0]} + {1'b0, st_reg.win[st_reg.sel].width} <=
              {1'b0, FULL_W})
            st_next.win[st_reg.sel].xoff = i_avs_writedata[11:0];
        `AFW_OFS_WIDTH:
          if ({1'b0, st_reg.win[st_reg.sel].xoff} + {1'b0, i_avs_writedata[11:0] & step_mask} <=
              {1'b0, FULL_W})
            st_next.win[st_reg.sel].width = i_avs_writedata[11:0] & step_mask;
        `AFW_OFS_YOFF:
          if ({1'b0, i_avs_writedata[11:0]} + {1'b0, st_reg.win[st_reg.sel].height} <=
              {1'b0, FULL_H})
            st_next.win[st_reg.sel].yoff = i_avs_writedata[11:0];
        `AFW_OFS_HEIGHT:
          if ({1'b0, st_reg.win[st_reg.sel].yoff} + {1'b0, i_avs_writedata[11:0] & step_mask} <=
              {1'b0, FULL_H})
            st_next.win[st_reg.sel].height = i_avs_writedata[11:0] & step_mask;
        `AFW_OFS_ASSIGN:
          st_next.asg[st_reg.sel] = i_avs_writedata[1:0];
        `AFW_OFS_CONTROL:
        begin
          st_next.color = i_avs_writedata[`AFW_CTL_COLOR_BIT];
          st_next.bin   = i_avs_writedata[`AFW_CTL_BIN_BIT];
        end
        default:
          st_next.sel = st_reg.sel;
      endcase
    end
    st_next.rdata = 32'h0000_0000;
    if (req && i_avs_read)
    begin
      case (i_avs_address)
        `AFW_OFS_SELECT: st_next.rdata = {31'h0, st_reg.sel};
        `AFW_OFS_XOFF:   st_next.rdata = {20'h0, st_reg.win[st_reg.sel].xoff};
        `AFW_OFS_WIDTH:  st_next.rdata = {20'h0, st_reg.win[st_reg.sel].width};
        `AFW_OFS_YOFF:   st_next.rdata = {20'h0, st_reg.win[st_reg.sel].yoff};
        `AFW_OFS_HEIGHT: st_next.rdata = {20'h0, st_reg.win[st_reg.sel].height};
        `AFW_OFS_ASSIGN: st_next.rdata = {30'h0, st_reg.asg[st_reg.sel]};
        `AFW_OFS_CONTROL: st_next.rdata = {24'h0, st_reg.bin, st_reg.color, 6'h00};
        `AFW_OFS_STATUS: st_next.rdata = {26'h0, fn_adjust, fn_active};
        default:         st_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      st_reg        <= '0;
      st_reg.sel    <= `AFW_RST_SELECT;
      st_reg.win[0] <= '{`AFW_RST_XOFF, FULL_W, `AFW_RST_YOFF, FULL_H};
      st_reg.win[1] <= '{`AFW_RST_XOFF, FULL_W, `AFW_RST_YOFF, FULL_H};
      st_reg.asg[0] <= `AFW_RST_ASG_WIN0;
      st_reg.asg[1] <= `AFW_RST_ASG_WIN1;
    end
    else
      st_reg <= st_next;
  end

  // wait one cycle per access so read data come from a register
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !st_reg.ack;
  assign o_avs_readdata    = st_reg.rdata;

  a_win_x_in_sensor: assert property (@(posedge i_clk) disable iff (i_rst)
    ({1'b0, st_reg.win[0].xoff} + {1'b0, st_reg.win[0].width} <= {1'b0, FULL_W}) &&
    ({1'b0, st_reg.win[1].xoff} + {1'b0, st_reg.win[1].width} <= {1'b0, FULL_W}))
    else $error("window past sensor width");
  a_win_y_in_sensor: assert property (@(posedge i_clk) disable iff (i_rst)
    ({1'b0, st_reg.win[0].yoff} + {1'b0, st_reg.win[0].height} <= {1'b0, FULL_H}) &&
    ({1'b0, st_reg.win[1].yoff} + {1'b0, st_reg.win[1].height} <= {1'b0, FULL_H}))
    else $error("window past sensor height");
  a_reset_assign: assert property (@(posedge i_clk)
    $fell(i_rst) |-> st_reg.asg[0] == 2'h1 && st_reg.asg[1] == 2'h2)
    else $error("reset assignment wrong");
  a_gain_manual: assert property (@(posedge i_clk) disable iff (i_rst)
    (bright_reg.valid && !bright_reg.overlap) |=> o_gain_value == $past(i_manual_gain))
    else $error("gain not manual without overlap");
endmodule

// *** test/afw_pix_src.sv ***
// sensor readout model: raster frames of pixels with idle gaps
`timescale 1ns/1ps
module afw_pix_src
#(
  parameter int unsigned W = 16,
  parameter int unsigned H = 8
)
(
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_run,
  output afw_pkg::afw_pix_t o_pix
);
  int pos;
  initial pos = 0;
  initial o_pix = '0;
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pos <= 0;
      o_pix <= '0;
    end
    else
    begin
      // a frame starts only when asked and is never cut short
      if (pos != 0 || i_run)
        pos <= (pos == int'(W*H) + 7) ? 0 : pos + 1;
      o_pix.valid <= pos < int'(W*H) && (pos != 0 || i_run);
      o_pix.col <= 12'(pos % W);
      o_pix.row <= 12'(pos / W);
      o_pix.sof <= pos == 0 && i_run;
      o_pix.eol <= pos < int'(W*H) && pos % W == W - 1;
      o_pix.eof <= pos == int'(W*H) - 1;
      // idle data toggles so a stale sample can never look right
      o_pix.data <= (pos < int'(W*H)) ? 12'($urandom) : ~o_pix.data;
    end
  end
endmodule

// *** test/afw_top_tb_top.sv ***
// self-checking bench for the measurement window selector
`timescale 1ns/1ps
module afw_top_tb_top;
  localparam int unsigned W = 16;
  localparam int unsigned H = 8;
  logic               i_clk, i_rst, run, rd, wr, wreq, gadj, eadj, badj;
  logic [4:0]         adr;
  logic [3:0]         be;
  logic [31:0]        wdat, rdat, rdata, esum;
  logic [23:0]        ecnt;
  logic [11:0]        mgain, tgt, gval;
  afw_pkg::afw_pix_t  pix;
  afw_pkg::afw_win_t  img, wexp, full;
  afw_pkg::afw_stat_t bst, cst, bgot, cgot;
  int                 n_errors, tests_run, cyc, frames, n_gain, n_expo, n_bal;

  afw_top #(.SENSOR_W(W), .SENSOR_H(H), .NUM_WIN(2)) u_afw_top (.i_clk(i_clk), .i_rst(i_rst),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
    .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_pix(pix),
    .i_img(img), .i_manual_gain(mgain), .i_target(tgt), .o_bright_stat(bst),
    .o_color_stat(cst), .o_gain_adjust(gadj), .o_expo_adjust(eadj), .o_bal_adjust(badj),
    .o_gain_value(gval));
  afw_pix_src #(.W(W), .H(H)) u_afw_pix_src (.i_clk(i_clk), .i_rst(i_rst), .i_run(run),
    .o_pix(pix));

  initial
  begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // ******************************************************************
  // helpers
  // ******************************************************************
  function automatic bit in_win(afw_pkg::afw_pix_t p, afw_pkg::afw_win_t w);
    return p.col >= w.xoff && int'(p.col) < int'(w.xoff) + int'(w.width)
      && p.row >= w.yoff && int'(p.row) < int'(w.yoff) + int'(w.height);
  endfunction
  function automatic afw_pkg::afw_win_t rnd_win();
    int x, y;
    x = $urandom_range(0, W - 2);
    y = $urandom_range(0, H - 2);
    return '{12'(x), 12'(2 * $urandom_range(1, (W - x) / 2)), 12'(y),
      12'(2 * $urandom_range(1, (H - y) / 2))};
  endfunction
  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= d;
    do
    begin
      @(posedge i_clk);
      n++;
    end while (wreq !== 1'b0);
    rdat = rdata;
    chk(32'(n), 2, "answer time");
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rchk(input logic [4:0] a, input logic [31:0] exp, input string m);
    bus(1'b0, a, 0);
    chk(rdat, exp, m);
  endtask
  // width before offset so no step ever breaks the sensor bound
  task automatic set_win(input logic [31:0] sel, input afw_pkg::afw_win_t v);
    bus(1, 5'h00, sel);
    bus(1, 5'h04, 0);
    bus(1, 5'h0c, 0);
    bus(1, 5'h08, 32'(v.width));
    bus(1, 5'h04, 32'(v.xoff));
    bus(1, 5'h10, 32'(v.height));
    bus(1, 5'h0c, 32'(v.yoff));
  endtask
  task automatic wait_frames(input int n);
    int t;
    t = frames + n;
    while (frames < t)
      @(posedge i_clk);
    repeat (4) @(posedge i_clk);
  endtask

  // ******************************************************************
  // monitor: expected overlap statistics and pulse counts
  // ******************************************************************
  always @(posedge i_clk)
  begin
    cyc++;
    if (pix.valid)
    begin
      if (pix.sof)
      begin
        esum = 0;
        ecnt = 0;
      end
      if (in_win(pix, wexp) && in_win(pix, img))
      begin
        esum += 32'(pix.data);
        ecnt++;
      end
      if (pix.eof)
        frames++;
    end
    if (bst.valid)
      bgot = bst;
    if (cst.valid)
      cgot = cst;
    n_gain += int'(gadj);
    n_expo += int'(eadj);
    n_bal += int'(badj);
    if (cyc > 40000)
    begin
      n_errors++;
      end_sim();
    end
  end

  // ******************************************************************
  // main sequence
  // ******************************************************************
  initial
  begin
    {n_errors, tests_run, cyc, frames, n_gain, n_expo, n_bal} = '0;
    {esum, ecnt, rd, wr, run, adr, wdat} = '0;
    full = '{12'h000, 12'(W), 12'h000, 12'(H)};
    img = full;
    wexp = full;
    be = 4'hf;
    mgain = 12'h000;
    tgt = 12'h000;
    i_rst = 1'b1;
    void'($urandom(23));
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    rchk(5'h00, 0, "sel");
    rchk(5'h04, 0, "xoff");
    rchk(5'h08, W, "width");
    rchk(5'h10, H, "height");
    rchk(5'h14, 1, "asg0");
    rchk(5'h01, 0, "unmapped");
    bus(1, 5'h00, 1);
    rchk(5'h14, 2, "asg1");
    bus(1, 5'h04, 2);
    rchk(5'h04, 0, "xbound");
    bus(1, 5'h0c, 1);
    rchk(5'h0c, 0, "ybound");
    be <= 4'he;
    bus(1, 5'h08, 6);
    be <= 4'hf;
    rchk(5'h08, W, "byteen");
    bus(1, 5'h08, 5);
    rchk(5'h08, 4, "step2");
    bus(1, 5'h18, 32'h40);
    bus(1, 5'h08, 6);
    rchk(5'h08, 4, "step4");
    bus(1, 5'h18, 0);
    bus(1, 5'h00, 0);
    rchk(5'h08, W, "separate");
    run <= 1'b1;
    // first pass is a hand-picked disjoint pair, the rest random
    for (int i = 0; i < 6; i++)
    begin
      wexp = (i == 0) ? '{12'h000, 12'h004, 12'h000, 12'(H)} : rnd_win();
      img <= (i == 0) ? '{12'h008, 12'h008, 12'h000, 12'(H)} : rnd_win();
      set_win(0, wexp);
      wait_frames(2);
      chk(32'(bgot.count), 32'(ecnt), "count");
      chk(bgot.sum, esum, "sum");
      chk(32'(bgot.overlap), 32'(ecnt != 0), "overlap");
    end
    wexp = full;
    img <= full;
    mgain <= 12'($urandom);
    tgt <= 12'($urandom);
    set_win(0, full);
    bus(1, 5'h18, 32'h02);
    n_gain = 0;
    n_expo = 0;
    n_bal = 0;
    wait_frames(1);
    chk(32'(n_gain), 0, "early adjust");
    wait_frames(4);
    chk(32'(n_gain != 0), 1, "gain adjust");
    chk(32'(n_expo), 0, "expo adjust");
    chk(32'(n_bal), 0, "balance adjust");
    img <= '{12'h008, 12'h008, 12'h000, 12'(H)};
    set_win(0, '{12'h000, 12'h004, 12'h000, 12'(H)});
    wait_frames(1);
    n_gain = 0;
    wait_frames(2);
    chk(32'(n_gain), 0, "no overlap adjust");
    chk(32'(gval), 32'(mgain), "manual gain");
    img <= full;
    tgt <= 12'hfff;
    set_win(0, full);
    bus(1, 5'h18, 32'h01);
    wait_frames(3);
    bus(0, 5'h1c, 0);
    chk(32'(rdat[0]), 1, "once active");
    wait_frames(33);
    bus(0, 5'h1c, 0);
    chk(32'(rdat[0]), 0, "once stop");
    bus(1, 5'h18, 0);
    wexp = '{12'h002, 12'h008, 12'h002, 12'h004};
    set_win(1, wexp);
    bus(1, 5'h14, 3);
    bus(1, 5'h00, 0);
    bus(1, 5'h14, 0);
    wait_frames(2);
    chk(bgot.sum, esum, "shared bright");
    chk(cgot.sum, esum, "shared color");
    run <= 1'b0;
    end_sim();
  end
endmodule
